/* logic/indirect_addresser.sv */
// Purpose: effective address generation for indirect data memory access
// Assumes: datapath gives one operand access per cycle, memory answers same cycle
// Notes: registered outputs; memory request issued the cycle after the operand
//
// How it works
// - three pointers, each high and low byte
// - pointer gives 12-bit effective address
// - virtual ports redirect to pointed location
// - plain port leaves pointer unchanged
// - post-decrement uses value then decrements
// - post-increment uses value then increments
// - pre-increment increments then uses value
// - indexed adds signed working register, no change
// - updates carry across all twelve bits
// - updates leave status flags alone
// - read of port indirectly returns zero, sets Z
// - write of port indirectly is no-operation
// - indirect write to pointer byte suppresses update
`include "indirect_params.svh"
`timescale 1ns/10ps
`default_nettype none
module indirect_addresser (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // operand from the datapath
    input wire logic op_valid_i,
    input wire logic op_write_i,
    input wire logic [11:0] op_addr_i,
    input wire logic [7:0] op_wdata_i,
    input wire logic [7:0] working_register_i,
    // data memory side
    input wire logic [7:0] mem_rdata_i,
    output logic mem_valid_o,
    output logic mem_write_o,
    output logic [11:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    // result to the datapath
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic zero_set_o,
    output logic flags_hold_o,
    // pointer values for observation
    output logic [35:0] pointers_o
);
    import indirect_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [2:0][7:0] ptr_high;
        logic [2:0][7:0] ptr_low;
        logic mem_valid;
        logic mem_write;
        logic [11:0] mem_addr;
        logic [7:0] mem_wdata;
        logic rd_valid;
        logic [7:0] rd_data;
        logic zero_set;
        logic flags_hold;
    } state_t;

    state_t state_reg;
    state_t state_next;

    port_decode_if op_dec ();
    port_decode_if tgt_dec ();

    logic [11:0] cur_ptr;
    logic [11:0] inc_ptr;
    logic [11:0] dec_ptr;
    logic [11:0] eff_addr;
    logic [11:0] new_ptr;
    logic update;

    // ****************************************************************
    // operand classes
    // ****************************************************************
    // operand names a virtual port
    logic port_named;
    // pointer points at a virtual port
    logic target_port;
    // indirect write lands on a pointer byte
    logic target_ptr_write;
    // indirect access goes on to data memory
    logic target_memory;
    // operand names a pointer byte directly
    logic direct_ptr_write;
    logic direct_ptr_read;
    // operand is a plain data address
    logic plain_memory;
    // update of the accessing pointer is dropped
    logic suppress_update;
    // pointer byte named directly, for reads
    logic [7:0] ptr_byte_read;

    function automatic logic [11:0] ptr_value(input logic [7:0] high, input logic [7:0] low);
        ptr_value = {high[3:0], low};
    endfunction

    // one byte of one pointer, high or low
    function automatic logic [7:0] ptr_byte(input state_t s, input logic [1:0] n,
        input logic high);
        if (high) begin
            ptr_byte = s.ptr_high[n];
        end else begin
            ptr_byte = s.ptr_low[n];
        end
    endfunction

    port_decoder op_decoder (
        .dec(op_dec)
    );

    port_decoder tgt_decoder (
        .dec(tgt_dec)
    );

    assign op_dec.addr = op_addr_i;
    assign tgt_dec.addr = eff_addr;

    // ****************************************************************
    // address generation
    // ****************************************************************
    always_comb begin
        cur_ptr = ptr_value(state_reg.ptr_high[op_dec.ptr_sel],
            state_reg.ptr_low[op_dec.ptr_sel]);
        inc_ptr = cur_ptr + 12'h001;
        dec_ptr = cur_ptr - 12'h001;
        eff_addr = cur_ptr;
        new_ptr = cur_ptr;
        update = 1'b0;
        unique case (op_dec.mode)
            MODE_PLAIN: begin
                update = 1'b0;
            end
            MODE_POSTDEC: begin
                new_ptr = dec_ptr;
                update = 1'b1;
            end
            MODE_POSTINC: begin
                new_ptr = inc_ptr;
                update = 1'b1;
            end
            MODE_PREINC: begin
                eff_addr = inc_ptr;
                new_ptr = inc_ptr;
                update = 1'b1;
            end
            MODE_INDEXED: begin
                eff_addr = cur_ptr + {{4{working_register_i[7]}}, working_register_i};
            end
        endcase
    end

    // ****************************************************************
    // classification
    // ****************************************************************
    always_comb begin
        port_named = op_valid_i && op_dec.hit;
        target_port = port_named && tgt_dec.hit;
        target_ptr_write = port_named && !tgt_dec.hit && tgt_dec.hit_ptr_reg && op_write_i;
        target_memory = port_named && !tgt_dec.hit && !target_ptr_write;
        direct_ptr_write = op_valid_i && !op_dec.hit && op_dec.hit_ptr_reg && op_write_i;
        direct_ptr_read = op_valid_i && !op_dec.hit && op_dec.hit_ptr_reg && !op_write_i;
        plain_memory = op_valid_i && !op_dec.hit && !op_dec.hit_ptr_reg;
        // a write into a pointer byte wins over the automatic update
        suppress_update = target_ptr_write;
        ptr_byte_read = ptr_byte(state_reg, op_dec.reg_ptr, op_dec.reg_high);
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.mem_valid = 1'b0;
        state_next.mem_write = 1'b0;
        state_next.rd_valid = 1'b0;
        state_next.zero_set = 1'b0;
        state_next.flags_hold = 1'b0;
        // pointer points back at a port: zero read or silent write
        if (target_port) begin
            state_next.mem_addr = eff_addr;
            if (!op_write_i) begin
                state_next.rd_valid = 1'b1;
                state_next.rd_data = `READ_ZERO;
                state_next.zero_set = 1'b1;
            end else begin
                state_next.flags_hold = 1'b1;
            end
        end

        // pointer points at a pointer byte and the access writes it
        if (target_ptr_write) begin
            state_next.mem_addr = eff_addr;
            if (tgt_dec.reg_high) begin
                state_next.ptr_high[tgt_dec.reg_ptr] = op_wdata_i;
            end else begin
                state_next.ptr_low[tgt_dec.reg_ptr] = op_wdata_i;
            end
            state_next.flags_hold = 1'b1;
        end

        // pointer points at ordinary data, or the access reads a pointer byte
        if (target_memory) begin
            state_next.mem_addr = eff_addr;
            state_next.mem_valid = 1'b1;
            state_next.mem_write = op_write_i;
            state_next.mem_wdata = op_wdata_i;
        end

        // automatic update of the accessing pointer
        if (port_named && update && !suppress_update) begin
            state_next.ptr_high[op_dec.ptr_sel] = {4'h0, new_ptr[11:8]};
            state_next.ptr_low[op_dec.ptr_sel] = new_ptr[7:0];
        end

        // pointer bytes named directly
        if (direct_ptr_write) begin
            if (op_dec.reg_high) begin
                state_next.ptr_high[op_dec.reg_ptr] = op_wdata_i;
            end else begin
                state_next.ptr_low[op_dec.reg_ptr] = op_wdata_i;
            end
        end
        if (direct_ptr_read) begin
            state_next.rd_valid = 1'b1;
            state_next.rd_data = ptr_byte_read;
        end

        // plain data address passes straight through
        if (plain_memory) begin
            state_next.mem_valid = 1'b1;
            state_next.mem_write = op_write_i;
            state_next.mem_addr = op_addr_i;
            state_next.mem_wdata = op_wdata_i;
        end

        // memory read data returns one cycle after the request
        if (state_reg.mem_valid && !state_reg.mem_write) begin
            state_next.rd_valid = 1'b1;
            state_next.rd_data = mem_rdata_i;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mem_valid_o = state_reg.mem_valid;
    assign mem_write_o = state_reg.mem_write;
    assign mem_addr_o = state_reg.mem_addr;
    assign mem_wdata_o = state_reg.mem_wdata;
    assign rd_valid_o = state_reg.rd_valid;
    assign rd_data_o = state_reg.rd_data;
    assign zero_set_o = state_reg.zero_set;
    assign flags_hold_o = state_reg.flags_hold;

    generate
        for (genvar n = 0; n < 3; n++) begin : g_ptr_out
            assign pointers_o[n*12 +: 12] = ptr_value(state_reg.ptr_high[n],
                state_reg.ptr_low[n]);
        end
    endgenerate
endmodule // indirect_addresser
`default_nettype wire

/* logic/indirect_params.svh */
// Purpose: constants for the indirect data addressing block
// Assumes: 12-bit data space, pointer registers and ports at fixed data addresses
// Notes: addresses are parameters of the core map, defaults arbitrary but plausible
`ifndef INDIRECT_PARAMS_SVH
`define INDIRECT_PARAMS_SVH

`define ADDR_W 12
`define DATA_W 8
`define PTR_COUNT 3
// data address of the first port of pointer 0; ports of pointer n sit 8*n lower
`define PORT_BASE 12'hfef
`define PORT_STRIDE 12'h008
// data address of pointer 0 low byte; high byte follows; pointer n sits 8*n lower
`define PTR_LOW_BASE 12'hfe9
`define PTR_STRIDE 12'h008
`define PTR_RESET 8'h00
`define READ_ZERO 8'h00

`endif

/* logic/indirect_pkg.sv */
// Purpose: types for the indirect data addressing block
// Assumes: constants come from indirect_params.svh
// Notes: none
package indirect_pkg;
    // update mode chosen by which virtual port is named
    typedef enum logic [4:0] {
        MODE_PLAIN = 5'h01,
        MODE_POSTDEC = 5'h02,
        MODE_POSTINC = 5'h04,
        MODE_PREINC = 5'h08,
        MODE_INDEXED = 5'h10
    } port_mode_t;
endpackage

/* logic/port_decode_if.sv */
// Purpose: carries a decoded operand address between decoder and addresser
// Assumes: one operand per instruction cycle
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface port_decode_if;
    logic [11:0] addr;
    logic hit;
    logic [1:0] ptr_sel;
    indirect_pkg::port_mode_t mode;
    logic hit_ptr_reg;
    logic [1:0] reg_ptr;
    logic reg_high;
    modport decoder (input addr, output hit, ptr_sel, mode, hit_ptr_reg, reg_ptr, reg_high);
    modport user (output addr, input hit, ptr_sel, mode, hit_ptr_reg, reg_ptr, reg_high);
endinterface
`default_nettype wire

/* logic/port_decoder.sv */
// Purpose: classifies a data address as virtual port, pointer byte or plain memory
// Assumes: address map from indirect_params.svh
// Notes: purely combinational
`include "indirect_params.svh"
`timescale 1ns/10ps
`default_nettype none
module port_decoder (
    port_decode_if.decoder dec
);
    import indirect_pkg::*;

    logic [11:0] off;
    logic [11:0] roff;

    always_comb begin
        dec.hit = 1'b0;
        dec.ptr_sel = 2'd0;
        dec.mode = MODE_PLAIN;
        dec.hit_ptr_reg = 1'b0;
        dec.reg_ptr = 2'd0;
        dec.reg_high = 1'b0;
        off = 12'h000;
        roff = 12'h000;
        for (int n = 0; n < `PTR_COUNT; n++) begin
            off = `PORT_BASE - dec.addr - 12'(n * `PORT_STRIDE);
            if (off < 12'h005) begin
                dec.hit = 1'b1;
                dec.ptr_sel = 2'(n);
                unique case (off[2:0])
                    3'd0: dec.mode = MODE_PLAIN;
                    3'd1: dec.mode = MODE_POSTDEC;
                    3'd2: dec.mode = MODE_POSTINC;
                    3'd3: dec.mode = MODE_PREINC;
                    default: dec.mode = MODE_INDEXED;
                endcase
            end
            roff = dec.addr - `PTR_LOW_BASE + 12'(n * `PTR_STRIDE);
            if (roff < 12'h002) begin
                dec.hit_ptr_reg = 1'b1;
                dec.reg_ptr = 2'(n);
                dec.reg_high = roff[0];
            end
        end
    end
endmodule // port_decoder
`default_nettype wire

/* sim/data_memory.sv */
// Purpose: combinational data memory beside the addresser
// Assumes: read data valid in the request cycle
// Notes: idle read lines toggle so stale data never matches
`timescale 1ns/10ps
`default_nettype none
module data_memory (
    // clock
    input wire logic clock_i,
    // request
    input wire logic mem_valid_i,
    input wire logic mem_write_i,
    input wire logic [11:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    // answer
    output logic [7:0] mem_rdata_o
);
    logic [7:0] store [4096];
    logic [7:0] last_reg = 8'h00;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            store[i] = 8'(i) ^ 8'h5a;
        end
    end
    always @(posedge clock_i) begin
        if (mem_valid_i && mem_write_i) begin
            store[mem_addr_i] <= mem_wdata_i;
        end
        last_reg <= mem_rdata_o;
    end
    assign mem_rdata_o = (mem_valid_i && !mem_write_i) ? store[mem_addr_i] : ~last_reg;
endmodule // data_memory
`default_nettype wire

/* sim/indirect_checker.sv */
// Purpose: port assertions for the addresser
// Assumes: pointer 0 ports at their fixed addresses
// Notes: bound to every addresser instance
`timescale 1ns/10ps
`default_nettype none
module indirect_checker (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // operand and memory
    input wire logic op_valid_i,
    input wire logic op_write_i,
    input wire logic [11:0] op_addr_i,
    input wire logic [7:0] working_register_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_valid_o,
    input wire logic mem_write_o,
    input wire logic [11:0] mem_addr_o,
    // results
    input wire logic rd_valid_o,
    input wire logic [7:0] rd_data_o,
    input wire logic zero_set_o,
    input wire logic flags_hold_o,
    input wire logic [35:0] pointers_o
);
    logic rd0;
    assign rd0 = op_valid_i && !op_write_i && pointers_o[11:0] < 12'hfd9;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    chk_mem_cause: assert property (mem_valid_o |-> $past(op_valid_i))
        else $error("memory request without operand");
    chk_rd_cause: assert property (rd_valid_o |-> $past(op_valid_i) || $past(op_valid_i, 2))
        else $error("read result without operand");
    chk_rd_follow: assert property (mem_valid_o && !mem_write_o |=>
        rd_valid_o && rd_data_o == $past(mem_rdata_i))
        else $error("read data not returned");
    chk_zero_read: assert property (zero_set_o |-> rd_valid_o && rd_data_o == 8'h00)
        else $error("zero flag without zero data");
    chk_hold_nomem: assert property (flags_hold_o |-> !mem_valid_o)
        else $error("memory access on suppressed write");
    chk_plain_addr: assert property (rd0 && op_addr_i == 12'hfef |=> mem_valid_o &&
        mem_addr_o == $past(pointers_o[11:0]) && $stable(pointers_o[11:0]))
        else $error("plain port address wrong");
    chk_postdec_ptr: assert property (rd0 && op_addr_i == 12'hfee |=>
        pointers_o[11:0] == $past(pointers_o[11:0]) - 12'h001)
        else $error("post-decrement wrong");
    chk_postinc_ptr: assert property (rd0 && op_addr_i == 12'hfed |=>
        pointers_o[11:0] == $past(pointers_o[11:0]) + 12'h001)
        else $error("post-increment wrong");
    chk_preinc_addr: assert property (rd0 && op_addr_i == 12'hfec |=>
        mem_addr_o == $past(pointers_o[11:0]) + 12'h001)
        else $error("pre-increment address wrong");
    chk_index_addr: assert property (rd0 && op_addr_i == 12'hfeb |=> $stable(pointers_o[11:0])
        && mem_addr_o == $past(pointers_o[11:0]) + {{4{$past(working_register_i[7])}},
        $past(working_register_i)})
        else $error("indexed address wrong");
endmodule // indirect_checker
bind indirect_addresser indirect_checker chk (.clock_i, .reset_i, .op_valid_i, .op_write_i,
    .op_addr_i, .working_register_i, .mem_rdata_i, .mem_valid_o, .mem_write_o, .mem_addr_o,
    .rd_valid_o, .rd_data_o, .zero_set_o, .flags_hold_o, .pointers_o);
`default_nettype wire

/* sim/testbench.sv */
// Purpose: self-checking bench for the addresser
// Assumes: map of ports and pointer bytes as in the hand-over
// Notes: memory holds address xor 5a at start
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic op_valid_i = 1'b0;
    logic op_write_i = 1'b0;
    logic [11:0] op_addr_i = 12'h000;
    logic [7:0] op_wdata_i = 8'h00;
    logic [7:0] working_register_i = 8'h00;
    wire logic [7:0] mem_rdata_i;
    logic mem_valid_o, mem_write_o, rd_valid_o, zero_set_o, flags_hold_o;
    logic [11:0] mem_addr_o;
    logic [7:0] mem_wdata_o, rd_data_o;
    logic [35:0] pointers_o;
    int errors = 0;
    int checked = 0;
    always #2.5 clock_i = ~clock_i;
    indirect_addresser dut (.clock_i, .reset_i, .op_valid_i, .op_write_i, .op_addr_i,
        .op_wdata_i, .working_register_i, .mem_rdata_i, .mem_valid_o, .mem_write_o,
        .mem_addr_o, .mem_wdata_o, .rd_valid_o, .rd_data_o, .zero_set_o, .flags_hold_o,
        .pointers_o);
    data_memory mem (.clock_i, .mem_valid_i(mem_valid_o), .mem_write_i(mem_write_o),
        .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
    function automatic logic [11:0] ptr(input int n);
        return pointers_o[12*n+:12];
    endfunction
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic wr, input logic [11:0] a, input logic [7:0] d);
        // one idle edge keeps the lowering and raising of valid apart
        @(posedge clock_i);
        #1;
        op_valid_i = 1'b1;
        op_write_i = wr;
        op_addr_i = a;
        op_wdata_i = d;
        @(posedge clock_i);
        #1;
        op_valid_i = 1'b0;
    endtask
    task automatic set_ptr(input int n, input logic [11:0] v);
        op(1'b1, 12'hfe9 - 12'(8 * n), v[7:0]);
        op(1'b1, 12'hfea - 12'(8 * n), {4'h0, v[11:8]});
        cmp(ptr(n), v);
    endtask
    task automatic mode_walk;
        logic [11:0] p, ea, np;
        working_register_i = 8'h80;
        for (int m = 0; m < 5; m++) begin
            p = (m == 1) ? 12'h100 : 12'h0ff;
            ea = (m == 3) ? p + 12'h001 : (m == 4) ? p - 12'h080 : p;
            np = (m == 1) ? p - 12'h001 : (m == 2 || m == 3) ? p + 12'h001 : p;
            set_ptr(0, p);
            op(1'b0, 12'hfef - 12'(m), 8'h00);
            cmp({11'h0, mem_valid_o}, 12'h001);
            cmp(mem_addr_o, ea);
            cmp(ptr(0), np);
            @(posedge clock_i);
            #1;
            cmp({3'h0, rd_valid_o, rd_data_o}, {4'h1, ea[7:0] ^ 8'h5a});
        end
    endtask
    task automatic byte_write;
        set_ptr(2, 12'hfe9);
        op(1'b1, 12'hfdd, 8'h34);
        cmp({10'h0, flags_hold_o, mem_valid_o}, 12'h002);
        cmp(ptr(2), 12'hfe9);
        cmp(ptr(0), 12'h034);
    endtask
    task automatic port_access;
        set_ptr(1, 12'hfef);
        op(1'b0, 12'hfe7, 8'h00);
        cmp({9'h0, rd_valid_o, zero_set_o, mem_valid_o}, 12'h006);
        cmp({4'h0, rd_data_o}, 12'h000);
        op(1'b1, 12'hfe7, 8'h77);
        cmp({10'h0, flags_hold_o, mem_valid_o}, 12'h002);
    endtask
    task automatic wrap_write;
        set_ptr(2, 12'hfff);
        op(1'b0, 12'hfdd, 8'h00);
        cmp({11'h0, zero_set_o}, 12'h000);
        cmp(ptr(2), 12'h000);
        set_ptr(2, 12'h200);
        op(1'b1, 12'hdf + 12'hf00, 8'ha5);
        cmp({2'h0, mem_valid_o, mem_write_o, mem_wdata_o}, 12'h3a5);
        cmp(mem_addr_o, 12'h200);
        op(1'b0, 12'hfdf, 8'h00);
        @(posedge clock_i);
        #1;
        cmp({4'h0, rd_data_o}, 12'h0a5);
    endtask
    task automatic final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        cmp(pointers_o[11:0], 12'h000);
        mode_walk();
        byte_write();
        port_access();
        wrap_write();
        final_report();
    end
endmodule // testbench
`default_nettype wire
